// file: include/hpi_cfg_cfg.svh
// constants for the eight-bit host port access controller
`ifndef HPI_CFG_CFG_SVH
`define HPI_CFG_CFG_SVH

// avalon slave: byte addresses, one 32-bit word per register
`define HPI_AVS_AW 5
`define HPI_OFS_CONFIG 5'h00
`define HPI_OFS_ADDR 5'h04
`define HPI_OFS_WDATA 5'h08
`define HPI_OFS_CMD 5'h0C
`define HPI_OFS_RDATA 5'h10
`define HPI_OFS_STATUS 5'h14

// config register fields
`define HPI_CFG_W 14
`define HPI_F_ADDR_LO 0
`define HPI_F_ADDR_HI 1
`define HPI_F_SETUP_LO 2
`define HPI_F_SETUP_HI 3
`define HPI_F_STROBE_LO 4
`define HPI_F_STROBE_HI 7
`define HPI_F_HOLD_LO 8
`define HPI_F_HOLD_HI 9
`define HPI_F_RECOV_LO 10
`define HPI_F_RECOV_HI 13
`define HPI_CFG_RESET 14'h0232

// command and status bits
`define HPI_CMD_GO 0
`define HPI_CMD_READ 1
`define HPI_ST_BUSY 0
`define HPI_ST_DONE 1
`define HPI_ST_WAIT 2

// pin widths and phase counter width
`define HPI_PIN_AW 4
`define HPI_DW 8
`define HPI_CNT_W 4
`define HPI_CNT_ZERO 4'h0
`define HPI_CNT_ONE 4'h1

`endif

// file: include/hpi_pkg.sv
// types shared by the host port access controller
package hpi_pkg;
	typedef enum logic [2:0] {
		HPI_IDLE,
		HPI_ADDR,
		HPI_SETUP,
		HPI_STROBE,
		HPI_HOLD,
		HPI_RECOV
	} hpi_state_t;
endpackage

// file: include/hpi_phase_if.sv
// link between the access sequencer and its phase counter
`timescale 1ns/1ns
`include "hpi_cfg_cfg.svh"
interface hpi_phase_if;
	logic load;
	logic [`HPI_CNT_W-1:0] count;
	logic done;
	modport ctl (output load, output count, input done);
	modport cnt (input load, input count, output done);
endinterface

// file: design/hpi_phase_cnt.sv
// phase length counter: loaded with cycles minus one, done at zero
`timescale 1ns/1ns
`include "hpi_cfg_cfg.svh"
module hpi_phase_cnt (
	input wire logic mclk, // expansion bus clock
	input wire logic rst, // synchronous reset, active high
	hpi_phase_if.cnt ph // load request and done flag
);
	logic [`HPI_CNT_W-1:0] cnt_q;
	logic [`HPI_CNT_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (ph.load) begin
			cnt_d = ph.count;
		end else if (cnt_q != `HPI_CNT_ZERO) begin
			cnt_d = cnt_q - `HPI_CNT_ONE;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= `HPI_CNT_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign ph.done = (cnt_q == `HPI_CNT_ZERO);
endmodule

// file: design/hpi_ctrl.sv
// eight-bit host port access controller with avalon register slave
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "hpi_cfg_cfg.svh"

// What this block does
// - address phase lasts one clock past wait
// - setup phase lasts one clock past wait
// - address and strobe phases stall during wait
// - recovery parameter sets gap between accesses
// - write to write gap at least recovery plus address parameter plus 4 clocks, 4 to 22 clocks
// - strobe follows chip select within 4 clocks without wait
// - write strobe pulse lasts strobe parameter plus one clocks, 1 to 16 clocks without wait
// - write data valid before strobe rising edge
// - every phase counts expansion bus clocks
module hpi_ctrl (
	input wire logic mclk, // expansion bus clock, 250 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic [`HPI_AVS_AW-1:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lane enables
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall, high until answer
	output logic host_cs_n, // chip select to dsp, active low
	output logic host_data_strobe_one_n, // data strobe, active low
	output logic host_rnw, // high for read access
	output logic [`HPI_PIN_AW-1:0] host_addr, // host port address lines
	output logic [`HPI_DW-1:0] host_data_o, // data bus drive value
	output logic host_data_oe, // data bus drive enable
	input wire logic [`HPI_DW-1:0] host_data_i, // data bus pin level
	input wire logic dsp_wait_request // dsp asks to stretch, active high
);
	import hpi_pkg::*;

	// merge a 32-bit write into an old value under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// widen a two-bit phase parameter to counter width
	function automatic logic [`HPI_CNT_W-1:0] widen2(input logic [1:0] v);
		return {2'h0, v};
	endfunction

	hpi_phase_if ph ();

	hpi_phase_cnt hpi_phase_cnt_i (
		.mclk(mclk),
		.rst(rst),
		.ph(ph)
	);

	// bus slave state
	logic wr_q, wr_d;
	logic [31:0] rdata_q, rdata_d;
	logic [`HPI_CFG_W-1:0] cfg_q, cfg_d;
	logic [`HPI_PIN_AW-1:0] addr_reg_q, addr_reg_d;
	logic [`HPI_DW-1:0] wdata_q, wdata_d;
	logic [`HPI_DW-1:0] rx_q, rx_d;
	logic go_q, go_d;
	logic rd_cmd_q, rd_cmd_d;
	logic done_q, done_d;

	// access sequencer and pin state
	hpi_state_t st_q, st_d;
	logic cs_n_q, cs_n_d;
	logic hds_n_q, hds_n_d;
	logic rnw_q, rnw_d;
	logic [`HPI_PIN_AW-1:0] haddr_q, haddr_d;
	logic [`HPI_DW-1:0] hdo_q, hdo_d;
	logic hoe_q, hoe_d;
	logic acc_rd_q, acc_rd_d;

	// synchronisers for pins from the dsp
	logic wait_m_q, wait_s_q, wait_p_q;
	logic [`HPI_DW-1:0] din_m_q, din_s_q;

	logic commit;
	logic finish;
	logic stall;
	logic [31:0] wmerge;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_m_q <= 1'b0;
			wait_s_q <= 1'b0;
			wait_p_q <= 1'b0;
			din_m_q <= '0;
			din_s_q <= '0;
		end else begin
			wait_m_q <= dsp_wait_request;
			wait_s_q <= wait_m_q;
			wait_p_q <= wait_s_q;
			din_m_q <= host_data_i;
			din_s_q <= din_m_q;
		end
	end

	// an address, setup or strobe phase may end only once wait has been low for two samples,
	// which keeps it one further clock past the withdrawal
	assign stall = wait_s_q | wait_p_q;

	// ---------------- register slave ----------------
	always_comb begin
		wr_d = 1'b1;
		rdata_d = rdata_q;
		cfg_d = cfg_q;
		addr_reg_d = addr_reg_q;
		wdata_d = wdata_q;
		go_d = go_q;
		rd_cmd_d = rd_cmd_q;
		done_d = done_q;
		commit = avs_write & ~wr_q;
		wmerge = 32'h0;
		// one wait cycle on every access, read data prepared in it
		if ((avs_read | avs_write) & wr_q) begin
			wr_d = 1'b0;
			if (avs_read) begin
				case (avs_address)
					`HPI_OFS_CONFIG: rdata_d = {18'h0, cfg_q};
					`HPI_OFS_ADDR: rdata_d = {28'h0, addr_reg_q};
					`HPI_OFS_WDATA: rdata_d = {24'h0, wdata_q};
					`HPI_OFS_CMD: rdata_d = {30'h0, rd_cmd_q, go_q};
					`HPI_OFS_RDATA: rdata_d = {24'h0, rx_q};
					`HPI_OFS_STATUS: rdata_d = {29'h0, wait_s_q, done_q, st_q != HPI_IDLE};
					default: rdata_d = 32'h0;
				endcase
			end
		end
		if (commit) begin
			case (avs_address)
				`HPI_OFS_CONFIG: begin
					wmerge = be_merge({18'h0, cfg_q}, avs_writedata, avs_byteenable);
					cfg_d = wmerge[`HPI_CFG_W-1:0];
				end
				`HPI_OFS_ADDR: begin
					wmerge = be_merge({28'h0, addr_reg_q}, avs_writedata, avs_byteenable);
					addr_reg_d = wmerge[`HPI_PIN_AW-1:0];
				end
				`HPI_OFS_WDATA: begin
					wmerge = be_merge({24'h0, wdata_q}, avs_writedata, avs_byteenable);
					wdata_d = wmerge[`HPI_DW-1:0];
				end
				`HPI_OFS_CMD: begin
					// a start while an access is pending or running is dropped
					if (avs_byteenable[0] && avs_writedata[`HPI_CMD_GO] && !go_q && st_q == HPI_IDLE) begin
						go_d = 1'b1;
						rd_cmd_d = avs_writedata[`HPI_CMD_READ];
					end
				end
				`HPI_OFS_STATUS: begin
					if (avs_byteenable[0] && avs_writedata[`HPI_ST_DONE]) begin
						done_d = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (st_q == HPI_IDLE && go_q) begin
			go_d = 1'b0;
		end
		// completion set wins over a clear in the same cycle
		if (finish) begin
			done_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_q <= 1'b1;
			rdata_q <= 32'h0;
			cfg_q <= `HPI_CFG_RESET;
			addr_reg_q <= '0;
			wdata_q <= '0;
			go_q <= 1'b0;
			rd_cmd_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
			rdata_q <= rdata_d;
			cfg_q <= cfg_d;
			addr_reg_q <= addr_reg_d;
			wdata_q <= wdata_d;
			go_q <= go_d;
			rd_cmd_q <= rd_cmd_d;
			done_q <= done_d;
		end
	end

	// ---------------- access sequencer ----------------
	always_comb begin
		st_d = st_q;
		ph.load = 1'b0;
		ph.count = `HPI_CNT_ZERO;
		finish = 1'b0;
		acc_rd_d = acc_rd_q;
		rx_d = rx_q;
		haddr_d = haddr_q;
		hdo_d = hdo_q;
		case (st_q)
			HPI_IDLE: begin
				if (go_q) begin
					st_d = HPI_ADDR;
					ph.load = 1'b1;
					ph.count = widen2(cfg_q[`HPI_F_ADDR_HI:`HPI_F_ADDR_LO]);
					acc_rd_d = rd_cmd_q;
					haddr_d = addr_reg_q;
					hdo_d = wdata_q;
				end
			end
			HPI_ADDR: begin
				if (ph.done && !stall) begin
					st_d = HPI_SETUP;
					ph.load = 1'b1;
					ph.count = widen2(cfg_q[`HPI_F_SETUP_HI:`HPI_F_SETUP_LO]);
				end
			end
			HPI_SETUP: begin
				if (ph.done && !stall) begin
					st_d = HPI_STROBE;
					ph.load = 1'b1;
					ph.count = cfg_q[`HPI_F_STROBE_HI:`HPI_F_STROBE_LO];
				end
			end
			HPI_STROBE: begin
				if (ph.done && !stall) begin
					st_d = HPI_HOLD;
					ph.load = 1'b1;
					ph.count = widen2(cfg_q[`HPI_F_HOLD_HI:`HPI_F_HOLD_LO]);
					if (acc_rd_q) begin
						rx_d = din_s_q;
					end
				end
			end
			HPI_HOLD: begin
				if (ph.done) begin
					st_d = HPI_RECOV;
					ph.load = 1'b1;
					ph.count = cfg_q[`HPI_F_RECOV_HI:`HPI_F_RECOV_LO];
					finish = 1'b1;
				end
			end
			HPI_RECOV: begin
				// recovery plus at least two idle cycles gives a gap of parameter plus three before the address phase
				if (ph.done) begin
					st_d = HPI_IDLE;
				end
			end
			default: begin
				st_d = HPI_IDLE;
			end
		endcase
		// pins are decoded from the next state so they leave flops aligned with it
		cs_n_d = !(st_d == HPI_SETUP || st_d == HPI_STROBE || st_d == HPI_HOLD);
		hds_n_d = (st_d != HPI_STROBE);
		rnw_d = (st_d == HPI_IDLE || st_d == HPI_RECOV) ? 1'b1 : acc_rd_d;
		// write data driven through strobe and hold only, so it leads the strobe edge by the strobe width
		hoe_d = !acc_rd_d && (st_d == HPI_STROBE ||
			st_d == HPI_HOLD);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= HPI_IDLE;
			acc_rd_q <= 1'b0;
			rx_q <= '0;
			cs_n_q <= 1'b1;
			hds_n_q <= 1'b1;
			rnw_q <= 1'b1;
			haddr_q <= '0;
			hdo_q <= '0;
			hoe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			acc_rd_q <= acc_rd_d;
			rx_q <= rx_d;
			cs_n_q <= cs_n_d;
			hds_n_q <= hds_n_d;
			rnw_q <= rnw_d;
			haddr_q <= haddr_d;
			hdo_q <= hdo_d;
			hoe_q <= hoe_d;
		end
	end

	assign avs_waitrequest = wr_q;
	assign avs_readdata = rdata_q;
	assign host_cs_n = cs_n_q;
	assign host_data_strobe_one_n = hds_n_q;
	assign host_rnw = rnw_q;
	assign host_addr = haddr_q;
	assign host_data_o = hdo_q;
	assign host_data_oe = hoe_q;
endmodule

// file: tb/hpi_ctrl_properties.sv
// pin-level assertions for the host port controller
`timescale 1ns/1ns
module hpi_ctrl_properties (
	input wire logic mclk, // clock
	input wire logic rst, // reset
	input wire logic [4:0] avs_address, // address
	input wire logic avs_write, // write
	input wire logic [31:0] avs_writedata, // data
	input wire logic avs_waitrequest, // stall
	input wire logic host_cs_n, // select
	input wire logic host_data_strobe_one_n, // strobe
	input wire logic host_rnw, // direction
	input wire logic [7:0] host_data_o, // drive value
	input wire logic host_data_oe, // drive enable
	input wire logic dsp_wait_request // wait
);
	logic [3:0] rec_q;
	logic [5:0] gap_q;
	logic [2:0] slo_q;
	logic [1:0] hld_par_q;
	logic [2:0] hld_q;
	// recovery field is snooped from config writes, since it is not visible at the pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			rec_q <= 4'h0;
			hld_par_q <= 2'h2;
			gap_q <= 6'h3F;
		end else begin
			if (avs_write && !avs_waitrequest && avs_address == 5'h00) begin
				rec_q <= avs_writedata[13:10];
				hld_par_q <= avs_writedata[9:8];
			end
			gap_q <= !host_cs_n ? 6'h00 : (gap_q == 6'h3F ? gap_q : gap_q + 6'h01);
		end
		slo_q <= host_data_strobe_one_n ? 3'h0 : slo_q + 3'h1;
		hld_q <= (host_data_strobe_one_n && host_data_oe) ? hld_q + 3'h1 : 3'h0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low twice");
	AST_CS_TO_STB: assert property ($fell(host_cs_n) && !host_rnw |-> ##[1:4] !host_data_strobe_one_n)
		else $error("strobe late after select");
	AST_STB_WIDTH: assert property ($rose(host_data_strobe_one_n) && !host_rnw |-> slo_q == 3'h4 || slo_q == 3'h5)
		else $error("write strobe width");
	AST_DATA_SETUP: assert property (!host_data_strobe_one_n && !host_rnw |-> host_data_oe && $stable(host_data_o))
		else $error("write data moved in strobe");
	AST_DATA_HOLD: assert property ($fell(host_data_oe) |-> hld_q == {1'b0, hld_par_q} + 3'h1)
		else $error("write data not held");
	AST_DATA_STEADY: assert property (host_data_oe && $past(host_data_oe) |-> $stable(host_data_o))
		else $error("write data moved while driven");
	AST_DATA_LEAD: assert property ($rose(host_data_strobe_one_n) && !host_rnw |-> $past(host_data_oe, 4) && !$past(host_data_oe, 6))
		else $error("write data lead wrong");
	AST_GAP: assert property ($fell(host_cs_n) |-> gap_q >= {2'b00, rec_q} + 6'h02)
		else $error("gap too short");
	AST_STALL: assert property (dsp_wait_request[*4] ##0 !host_data_strobe_one_n |=> !host_data_strobe_one_n)
		else $error("strobe left during wait");
	AST_STB_IN_CS: assert property (!host_data_strobe_one_n |-> !host_cs_n)
		else $error("strobe without select");
	cover property ($rose(host_data_strobe_one_n) && !host_rnw);
	cover property (dsp_wait_request && !host_data_strobe_one_n);
	cover property ($fell(host_cs_n) && gap_q > 6'h10);
endmodule

// file: tb/hpi_dsp_model.sv
// behavioural model of the dsp host port
`timescale 1ns/1ns
module hpi_dsp_model (
	input wire logic mclk, // clock
	input wire logic host_cs_n, // select
	input wire logic host_data_strobe_one_n, // strobe
	input wire logic host_rnw, // direction
	input wire logic [7:0] host_data_o, // device data
	input wire logic host_data_oe, // device drives bus
	input wire logic stall_en, // stretch strobes
	input wire logic [7:0] rd_val, // byte returned
	output logic [7:0] host_data_i, // bus level
	output logic dsp_wait_request, // wait
	output logic [7:0] wr_seen // last byte written
);
	logic [7:0] last;
	logic [3:0] wcnt;
	logic sp;
	initial begin
		host_data_i = 8'h00;
		wr_seen = 8'h00;
		last = 8'h00;
		wcnt = 4'h0;
		sp = 1'b1;
	end
	assign dsp_wait_request = wcnt != 4'h0;
	always @(posedge mclk) begin
		sp <= host_data_strobe_one_n;
		// a released bus shows the inverse so stale data cannot pass
		host_data_i <= (!host_cs_n && host_rnw) ? rd_val : ~last;
		if (!host_cs_n && host_rnw)
			last <= rd_val;
		if (stall_en && sp && !host_data_strobe_one_n)
			wcnt <= 4'h6;
		else if (wcnt != 4'h0)
			wcnt <= wcnt - 4'h1;
		if (host_data_strobe_one_n && !sp && !host_rnw)
			wr_seen <= host_data_oe ? host_data_o : ~host_data_o;
	end
endmodule

// file: tb/hpi_ctrl_bench.sv
// self-checking bench for the host port controller
`timescale 1ns/1ns
`include "hpi_cfg_cfg.svh"
module hpi_ctrl_bench;
	logic mclk, rst, rd, wr, stall_en, ws, cs_n, stb_n, rnw, oe, dwait;
	logic [4:0] adr;
	logic [31:0] wd, rdata, q;
	logic [7:0] rd_val, hdi, hdo, seen;
	logic [3:0] haddr;
	int error_cnt, num_checks, gap, last_gap;
	hpi_ctrl hpi_ctrl_i (.mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(ws),
		.host_cs_n(cs_n), .host_data_strobe_one_n(stb_n), .host_rnw(rnw), .host_addr(haddr),
		.host_data_o(hdo), .host_data_oe(oe), .host_data_i(hdi), .dsp_wait_request(dwait));
	hpi_dsp_model hpi_dsp_model_i (.mclk(mclk), .host_cs_n(cs_n), .host_data_strobe_one_n(stb_n),
		.host_rnw(rnw), .host_data_o(hdo), .host_data_oe(oe), .stall_en(stall_en), .rd_val(rd_val), .host_data_i(hdi),
		.dsp_wait_request(dwait), .wr_seen(seen));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		gap <= cs_n ? gap + 1 : 0;
		if (!cs_n && gap != 0)
			last_gap <= gap;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task av_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		do @(posedge mclk); while (ws !== 1'b0);
		wr <= 1'b0;
	endtask
	task av_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge mclk);
		adr <= a;
		rd <= 1'b1;
		do @(posedge mclk); while (ws !== 1'b0);
		d = rdata;
		rd <= 1'b0;
	endtask
	task poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			av_rd(`HPI_OFS_STATUS, q);
			n++;
		end while (q[b] !== v && n < 100);
		// a poll that runs out is a hang of the access engine
		if (q[b] !== v) begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	// waiting for idle first keeps a go from landing in recovery, where it is ignored
	task go(input logic [31:0] c);
		poll(0, 1'b0);
		av_wr(`HPI_OFS_CMD, c);
		poll(1, 1'b1);
		chk(q & 32'h2, 32'h2);
		av_wr(`HPI_OFS_STATUS, 32'h2);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		adr = 5'h00;
		wd = 32'h0;
		stall_en = 1'b0;
		rd_val = 8'h3C;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		av_rd(`HPI_OFS_CONFIG, q);
		chk(q, 32'h232);
		av_wr(`HPI_OFS_RDATA, 32'hFF);
		av_rd(`HPI_OFS_RDATA, q);
		chk(q, 32'h0);
		av_rd(5'h18, q);
		chk(q, 32'h0);
		$display("test registers done");
		av_wr(`HPI_OFS_CONFIG, 32'h23A);
		av_wr(`HPI_OFS_ADDR, 32'h5);
		av_wr(`HPI_OFS_WDATA, 32'hA5);
		go(32'h1);
		chk(32'(seen), 32'hA5);
		chk(32'(haddr), 32'h5);
		$display("test write done");
		stall_en <= 1'b1;
		go(32'h3);
		stall_en <= 1'b0;
		av_rd(`HPI_OFS_RDATA, q);
		chk(q, 32'h3C);
		$display("test stalled read done");
		av_wr(`HPI_OFS_CONFIG, 32'h3C3A);
		go(32'h1);
		go(32'h1);
		chk(32'(last_gap >= 20), 32'h1);
		$display("test recovery done");
		report_and_stop();
	end
endmodule
bind hpi_ctrl hpi_ctrl_properties hpi_ctrl_properties_i (.*);
